//--- rtl/did_decoder.v
// Operation
// RQ1 - 0111 0010 loads multiplicand, accumulates, moves
// RQ2 - 0111 0001 loads multiplicand, product to acc
// RQ3 - 0111 0100 loads multiplicand, subtracts product
// RQ4 - 1010 0010/0011 multiply-accumulate, two words three cycles
// RQ5 - 1000 1011 modify aux register; zero byte nop
// RQ6 - 0101 0100 multiply; 110C multiply immediate
// RQ7 - 0101 0000 multiply and add previous product
// RQ8 - 0101 0001 multiply and subtract previous product
// RQ9 - 1010 0000 normalise accumulator, one cycle
// RQ10 - OR immediate forms, two words two cycles
// RQ11 - be32 pops stack to low accumulator
// RQ12 - 1000 1010 pop to memory, 0111 0110 push
// RQ13 - be3c pushes low accumulator onto stack
// RQ14 - Conditional return four taken, two not
// RQ15 - Repeat count from immediate or memory
// RQ16 - 1001 stores high or low accumulator shifted
// RQ17 - Status prefix low nibble selects action
// RQ18 - Status actions: flag, carry, overflow, test, sign
// RQ19 - 1010 1110 stores long immediate, two words
// RQ20 - 0110 0110 subtract no extension, 0100 borrow
// RQ21 - Table read and write, three cycles
// RQ22 - XOR immediate forms, two words two cycles
// RQ23 - 0110 1000 zero, load high, round
// RQ24 - Two-word ops fetch second word as operand
// RQ25 - Multi-cycle ops stall later fetches; code stalls only ops of three or four cycles
`timescale 1ns/1ps
`default_nettype none
`include "did_defs.vh"
module did_decoder #(
  parameter WORD_W = 16
) (
  input  wire              i_ref_clk,      // Core clock, 40 MHz.
  input  wire              i_resetn,       // Synchronous reset, active low.
  input  wire              i_fetch_valid,  // Program word present.
  input  wire [WORD_W-1:0] i_fetch_word,   // Program word.
  input  wire              i_cond_true,    // Return condition met.
  output reg               o_fetch_ready,  // Decoder accepts a word.
  output reg               o_op_valid,     // Decoded op pulse.
  output reg  [5:0]        o_op_code,      // Decoded operation.
  output reg  [WORD_W-1:0] o_op_word,      // First instruction word.
  output reg  [WORD_W-1:0] o_operand,      // Second word, if any.
  output reg  [1:0]        o_op_words,     // Word count.
  output reg  [2:0]        o_op_cycles,    // Execute cycle count.
  output reg               o_unknown,      // Word outside this range.
  output reg               o_external_flag_output, // External flag pin.
  output reg               o_carry,        // Carry set by status op.
  output reg               o_ovf_mode,     // Overflow mode.
  output reg               o_test_flag,    // Test/control flag.
  output reg               o_sign_ext,     // Sign extension mode.
  output reg               o_int_disable,  // Interrupts disabled.
  output reg               o_blk_program   // Block is program memory.
);
  localparam ST_FIRST  = 2'h0;
  localparam ST_SECOND = 2'h1;
  localparam ST_STALL  = 2'h2;

  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [5:0] dec_code;
  reg  [1:0] dec_words;
  reg  [2:0] dec_cycles;
  reg        dec_known;
  reg  [5:0] pend_code_r;
  reg  [2:0] pend_cycles_r;
  wire [WORD_W-1:0] first_word;
  wire       stall_busy;
  wire       take_first;
  wire       take_second;
  wire       issue;
  wire [2:0] issue_cycles;

  // Returns the cycle count of a conditional return.
  function [2:0] ret_cycles;
    input taken;
    begin
      ret_cycles = taken ? `DID_CYC_FOUR : `DID_CYC_TWO; // [RQ14]
    end
  endfunction

  // Decodes one first word into operation, words and cycles.
  always @* begin
    dec_code   = `DID_OP_NONE;
    dec_words  = 2'h1;
    dec_cycles = `DID_CYC_ONE;
    dec_known  = 1'b1;
    if (i_fetch_word == `DID_W_POP_ACC) begin
      dec_code = `DID_OP_POP_ACC; // [RQ11]
    end else if (i_fetch_word == `DID_W_PUSH_ACC) begin
      dec_code = `DID_OP_PUSH_ACC; // [RQ13]
    end else if (i_fetch_word == `DID_W_OR_16) begin
      dec_code   = `DID_OP_OR_16; // [RQ10]
      dec_words  = 2'h2;
      dec_cycles = `DID_CYC_TWO;
    end else if (i_fetch_word == `DID_W_XOR_16) begin
      dec_code   = `DID_OP_XOR_16; // [RQ22]
      dec_words  = 2'h2;
      dec_cycles = `DID_CYC_TWO;
    end else if (i_fetch_word == `DID_W_RET) begin
      dec_code   = `DID_OP_RET; // [RQ14]
      dec_cycles = `DID_CYC_FOUR;
    end else if (i_fetch_word[15:4] == `DID_ST_PREFIX) begin
      dec_code = `DID_OP_SET_CONTROL_BIT_OP; // [RQ17]
      case (i_fetch_word[3:0])
        `DID_ST_PROG_BLK, `DID_ST_INT_DIS, `DID_ST_XF_SET, `DID_ST_CARRY,
        `DID_ST_OVM, `DID_ST_TC, `DID_ST_SXM: dec_known = 1'b1;
        default: begin
          dec_code  = `DID_OP_NONE;
          dec_known = 1'b0;
        end
      endcase
    end else if (i_fetch_word[15:4] == 12'hbfc) begin
      dec_code   = `DID_OP_OR_SHF; // [RQ10]
      dec_words  = 2'h2;
      dec_cycles = `DID_CYC_TWO;
    end else if (i_fetch_word[15:4] == 12'hbfd) begin
      dec_code   = `DID_OP_XOR_SHF; // [RQ22]
      dec_words  = 2'h2;
      dec_cycles = `DID_CYC_TWO;
    end else if (i_fetch_word[15:10] == 6'h3b) begin
      dec_code   = `DID_OP_CONDITIONAL_RETURN_OP; // [RQ14]
      dec_cycles = ret_cycles(i_cond_true);
    end else if (i_fetch_word[15:13] == 3'h6) begin
      dec_code = `DID_OP_MPY_IMM; // [RQ6]
    end else if (i_fetch_word[15:12] == 4'h9) begin
      dec_code = i_fetch_word[11] ? `DID_OP_STORE_HIGH_ACC_OP : `DID_OP_STORE_LOW_ACC_OP; // [RQ16]
    end else begin
      case (i_fetch_word[15:8])
        8'h72: dec_code = `DID_OP_LOAD_ACC_MOVE; // [RQ1]
        8'h71: dec_code = `DID_OP_LTP; // [RQ2]
        8'h74: dec_code = `DID_OP_LTS; // [RQ3]
        8'ha2, 8'ha3: begin
          dec_code   = i_fetch_word[8] ? `DID_OP_MULTIPLY_ACCUMULATE_MOVE_OP : `DID_OP_MAC; // [RQ4]
          dec_words  = 2'h2;
          dec_cycles = `DID_CYC_THREE;
        end
        8'h8b: dec_code = (i_fetch_word[7:0] == 8'h00) ?
                          `DID_OP_NOP : `DID_OP_MAR; // [RQ5]
        8'h54: dec_code = `DID_OP_MPY; // [RQ6]
        8'h50: dec_code = `DID_OP_MULTIPLY_ADD_PREV_OP; // [RQ7]
        8'h51: dec_code = `DID_OP_MULTIPLY_SUB_PREV_OP; // [RQ8]
        8'ha0: dec_code = `DID_OP_NORMALISE_ACC_OP; // [RQ9]
        8'h8a: dec_code = `DID_OP_POP_TO_MEMORY_OP; // [RQ12]
        8'h76: dec_code = `DID_OP_PUSH_FROM_MEMORY_OP; // [RQ12]
        8'hbb: dec_code = `DID_OP_RPT_IMM; // [RQ15]
        8'h0b: dec_code = `DID_OP_RPT_MEM; // [RQ15]
        8'hae: begin
          dec_code   = `DID_OP_STORE_LONG_IMMEDIATE_OP; // [RQ19]
          dec_words  = 2'h2;
          dec_cycles = `DID_CYC_TWO;
        end
        8'h66: dec_code = `DID_OP_SUBTRACT_NO_SIGNEXT_OP; // [RQ20]
        8'h64: dec_code = `DID_OP_SUBTRACT_BORROW_OP; // [RQ20]
        8'ha6, 8'ha7: begin
          dec_code   = i_fetch_word[8] ? `DID_OP_TABLE_WRITE_OP : `DID_OP_TABLE_READ_OP; // [RQ21]
          dec_cycles = `DID_CYC_THREE;
        end
        8'h68: dec_code = `DID_OP_ZERO_LOAD_ROUND_OP; // [RQ23]
        default: dec_known = 1'b0;
      endcase
    end
  end

  // A word is only taken while ready is shown, so nothing moves just
  // after reset or during a stall even if the fetch path offers a word.
  assign take_first  = (state_r == ST_FIRST) && i_fetch_valid &&
                       o_fetch_ready;
  assign take_second = (state_r == ST_SECOND) && i_fetch_valid &&
                       o_fetch_ready;
  // Unknown words raise their own pulse and never issue.
  assign issue = (take_first && (dec_words == 2'h1) && dec_known) ||
                 take_second;
  assign issue_cycles = take_second ? pend_cycles_r : dec_cycles;

  // Keeps the first word of a two-word op while its operand is fetched.
  did_word_reg #(
    .WIDTH (WORD_W)
  ) u_first (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_load    (take_first),
    .i_d       (i_fetch_word),
    .o_q       (first_word)
  );

  // Counts extra execute cycles of two-, three- and four-cycle ops.
  did_stall_cnt u_stall (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_start   (issue),
    .i_cycles  (issue_cycles),
    .o_busy    (stall_busy)
  );

  // Chooses the next fetch state.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_FIRST: begin
        if (take_first && dec_words == 2'h2) begin
          state_nxt = ST_SECOND; // [RQ24]
        end else if (issue && dec_cycles > `DID_CYC_TWO) begin
          state_nxt = ST_STALL; // [RQ25]
        end
      end
      ST_SECOND: begin
        if (take_second) begin
          state_nxt = (pend_cycles_r > `DID_CYC_TWO) ?
                      ST_STALL : ST_FIRST; // [RQ25]
        end
      end
      ST_STALL: begin
        if (!stall_busy && !o_fetch_ready) begin
          state_nxt = ST_STALL;
        end
        if (stall_busy == 1'b0 && o_op_valid == 1'b0) begin
          state_nxt = ST_FIRST; // [RQ25]
        end
      end
      default: state_nxt = ST_FIRST;
    endcase
  end

  // State, pending op and ready register.
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state_r       <= ST_FIRST;
      pend_code_r   <= `DID_OP_NONE;
      pend_cycles_r <= `DID_CYC_ONE;
      o_fetch_ready <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take_first) begin
        pend_code_r   <= dec_code;
        pend_cycles_r <= dec_cycles;
      end
      o_fetch_ready <= (state_nxt != ST_STALL); // [RQ25]
    end
  end

  // Issues the decoded op with its operand word.
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_op_valid  <= 1'b0;
      o_op_code   <= `DID_OP_NONE;
      o_op_word   <= {WORD_W{1'b0}};
      o_operand   <= {WORD_W{1'b0}};
      o_op_words  <= 2'h0;
      o_op_cycles <= 3'h0;
      o_unknown   <= 1'b0;
    end else begin
      o_op_valid <= issue && o_fetch_ready;
      o_unknown  <= take_first && !dec_known && o_fetch_ready;
      if (take_first && dec_words == 2'h1) begin
        o_op_code   <= dec_code;
        o_op_word   <= i_fetch_word;
        o_operand   <= {WORD_W{1'b0}};
        o_op_words  <= dec_words;
        o_op_cycles <= dec_cycles;
      end else if (take_second) begin
        o_op_code   <= pend_code_r;
        o_op_word   <= first_word;
        o_operand   <= i_fetch_word; // [RQ24]
        o_op_words  <= 2'h2;
        o_op_cycles <= pend_cycles_r;
      end
    end
  end

  // Applies status actions when a status op issues.
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_external_flag_output <= 1'b0;
      o_carry       <= 1'b0;
      o_ovf_mode    <= 1'b0;
      o_test_flag   <= 1'b0;
      o_sign_ext    <= 1'b0;
      o_int_disable <= 1'b0;
      o_blk_program <= 1'b0;
    end else if (take_first && o_fetch_ready &&
                 dec_code == `DID_OP_SET_CONTROL_BIT_OP) begin
      case (i_fetch_word[3:0])
        `DID_ST_XF_SET:   o_external_flag_output <= 1'b1; // [RQ18]
        `DID_ST_CARRY:    o_carry       <= 1'b1; // [RQ18]
        `DID_ST_OVM:      o_ovf_mode    <= 1'b1; // [RQ18]
        `DID_ST_TC:       o_test_flag   <= 1'b1; // [RQ18]
        `DID_ST_SXM:      o_sign_ext    <= 1'b1; // [RQ18]
        `DID_ST_INT_DIS:  o_int_disable <= 1'b1; // [RQ17]
        `DID_ST_PROG_BLK: o_blk_program <= 1'b1; // [RQ17]
        default:          o_carry       <= o_carry;
      endcase
    end
  end
endmodule // did_decoder
`default_nettype wire

//--- rtl/did_defs.vh
`ifndef DID_DEFS_VH
`define DID_DEFS_VH
// Decoded operation codes.
`define DID_OP_NONE        6'h00
`define DID_OP_LOAD_ACC_MOVE 6'h01
`define DID_OP_LTP         6'h02
`define DID_OP_LTS         6'h03
`define DID_OP_MAC         6'h04
`define DID_OP_MULTIPLY_ACCUMULATE_MOVE_OP        6'h05
`define DID_OP_MAR         6'h06
`define DID_OP_NOP         6'h07
`define DID_OP_MPY         6'h08
`define DID_OP_MPY_IMM     6'h09
`define DID_OP_MULTIPLY_ADD_PREV_OP        6'h0a
`define DID_OP_MULTIPLY_SUB_PREV_OP        6'h0b
`define DID_OP_NORMALISE_ACC_OP        6'h0c
`define DID_OP_OR_SHF      6'h0d
`define DID_OP_OR_16       6'h0e
`define DID_OP_POP_ACC     6'h0f
`define DID_OP_POP_TO_MEMORY_OP        6'h10
`define DID_OP_PUSH_FROM_MEMORY_OP        6'h11
`define DID_OP_PUSH_ACC    6'h12
`define DID_OP_RET         6'h13
`define DID_OP_CONDITIONAL_RETURN_OP        6'h14
`define DID_OP_RPT_IMM     6'h15
`define DID_OP_RPT_MEM     6'h16
`define DID_OP_STORE_HIGH_ACC_OP        6'h17
`define DID_OP_STORE_LOW_ACC_OP        6'h18
`define DID_OP_SET_CONTROL_BIT_OP        6'h19
`define DID_OP_STORE_LONG_IMMEDIATE_OP        6'h1a
`define DID_OP_SUBTRACT_NO_SIGNEXT_OP        6'h1b
`define DID_OP_SUBTRACT_BORROW_OP        6'h1c
`define DID_OP_TABLE_READ_OP        6'h1d
`define DID_OP_TABLE_WRITE_OP        6'h1e
`define DID_OP_XOR_SHF     6'h1f
`define DID_OP_XOR_16      6'h20
`define DID_OP_ZERO_LOAD_ROUND_OP        6'h21
// Status action low nibbles under the status prefix.
`define DID_ST_PREFIX      12'hbe4
`define DID_ST_PROG_BLK    4'h5
`define DID_ST_INT_DIS     4'h1
`define DID_ST_XF_SET      4'hd
`define DID_ST_CARRY       4'hf
`define DID_ST_OVM         4'h3
`define DID_ST_TC          4'hb
`define DID_ST_SXM         4'h7
// Fixed full-word codes.
`define DID_W_POP_ACC      16'hbe32
`define DID_W_PUSH_ACC     16'hbe3c
`define DID_W_OR_16        16'hbe82
`define DID_W_XOR_16       16'hbe83
`define DID_W_RET          16'hef00
// Cycle counts.
`define DID_CYC_ONE        3'h1
`define DID_CYC_TWO        3'h2
`define DID_CYC_THREE      3'h3
`define DID_CYC_FOUR       3'h4
`endif

//--- rtl/did_stall_cnt.v
`timescale 1ns/1ps
`default_nettype none
module did_stall_cnt (
  input  wire       i_ref_clk, // Core clock.
  input  wire       i_resetn,  // Synchronous reset, active low.
  input  wire       i_start,   // Load the count.
  input  wire [2:0] i_cycles,  // Total execute cycles.
  output reg        o_busy     // High while extra cycles remain.
);
  reg [2:0] cnt_r;
  // Counts the extra execute cycles beyond the first.
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      cnt_r  <= 3'h0;
      o_busy <= 1'b0;
    end else if (i_start && i_cycles > 3'h1) begin
      cnt_r  <= i_cycles - 3'h1;
      o_busy <= 1'b1;
    end else if (cnt_r != 3'h0) begin
      cnt_r  <= cnt_r - 3'h1;
      o_busy <= (cnt_r > 3'h1);
    end else begin
      o_busy <= 1'b0;
    end
  end
endmodule // did_stall_cnt
`default_nettype wire

//--- rtl/did_word_reg.v
`timescale 1ns/1ps
`default_nettype none
module did_word_reg #(
  parameter WIDTH = 16
) (
  input  wire             i_ref_clk, // Core clock.
  input  wire             i_resetn,  // Synchronous reset, active low.
  input  wire             i_load,    // Capture strobe.
  input  wire [WIDTH-1:0] i_d,       // Word to capture.
  output reg  [WIDTH-1:0] o_q        // Captured word.
);
  // Holds a word until the next capture strobe.
  always @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_q <= {WIDTH{1'b0}};
    end else if (i_load) begin
      o_q <= i_d;
    end
  end
endmodule // did_word_reg
`default_nettype wire

//--- tb/did_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "did_defs.vh"
module did_decoder_chk #(
  parameter WORD_W = 16
) (
  input wire logic              i_ref_clk,     // Clock.
  input wire logic              i_resetn,      // Reset.
  input wire logic              i_fetch_valid, // Word offered.
  input wire logic [WORD_W-1:0] i_fetch_word,  // Offered word.
  input wire logic              i_cond_true,   // Return condition.
  input wire logic              o_fetch_ready, // Ready.
  input wire logic              o_op_valid,    // Issue pulse.
  input wire logic [5:0]        o_op_code,     // Code.
  input wire logic [WORD_W-1:0] o_op_word,     // First word.
  input wire logic [WORD_W-1:0] o_operand,     // Second word.
  input wire logic [1:0]        o_op_words,    // Word count.
  input wire logic [2:0]        o_op_cycles,   // Cycle count.
  input wire logic              o_unknown,     // Unknown word.
  input wire logic              o_external_flag_output, // Flag pin.
  input wire logic              o_int_disable  // Interrupts off.
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // Counts and codes of issued operations.
  chk_mac_counts: assert property (o_op_valid && o_op_word[15:9] == 7'h51
    |-> o_op_words == 2'h2 && o_op_cycles == 3'h3)
    else $error("multiply-accumulate counts wrong");
  chk_table_counts: assert property (o_op_valid && o_op_word[15:9] == 7'h53
    |-> o_op_words == 2'h1 && o_op_cycles == 3'h3)
    else $error("table move counts wrong");
  chk_or16_counts: assert property (o_op_valid && o_op_word == 16'hbe82
    |-> o_op_words == 2'h2 && o_op_cycles == 3'h2)
    else $error("shift-16 OR counts wrong");
  chk_xor_shift: assert property (o_op_valid && o_op_word[15:4] == 12'hbfd
    |-> o_op_code == `DID_OP_XOR_SHF && o_op_words == 2'h2)
    else $error("shifted XOR decode wrong");
  chk_long_store: assert property (o_op_valid && o_op_word[15:8] == 8'hae
    |-> o_op_code == `DID_OP_STORE_LONG_IMMEDIATE_OP && o_op_cycles == 3'h2)
    else $error("long immediate store decode wrong");
  chk_nop_code: assert property (o_op_valid && o_op_word == 16'h8b00
    |-> o_op_code == `DID_OP_NOP)
    else $error("zero byte not decoded as no operation");
  chk_cond_return: assert property (o_op_valid && o_op_code == `DID_OP_CONDITIONAL_RETURN_OP
    |-> o_op_cycles == ($past(i_cond_true) ? 3'h4 : 3'h2))
    else $error("conditional return cycle count wrong");
  // The operand is the word taken at the edge before the issue.
  chk_operand_word: assert property (o_op_valid && o_op_words == 2'h2
    |-> $past(o_fetch_ready && i_fetch_valid) && o_operand == $past(i_fetch_word))
    else $error("operand is not the second fetched word");
  chk_long_stall: assert property (o_op_valid && o_op_cycles >= 3'h3
    |-> !o_fetch_ready [*2] ##[1:6] o_fetch_ready)
    else $error("multi-cycle op did not stall fetch");
  chk_flag_set: assert property (o_op_valid && o_op_word == 16'hbe4d
    |-> ##[0:2] o_external_flag_output)
    else $error("external flag not driven high");
  chk_int_off: assert property (o_op_valid && o_op_word == 16'hbe41
    |-> ##[0:2] o_int_disable)
    else $error("interrupts not disabled");

  // Main scenarios reached.
  cov_two_word: cover property (o_op_valid && o_op_words == 2'h2);
  cov_four_cyc: cover property (o_op_valid && o_op_cycles == 3'h4);
  cov_unknown: cover property (o_unknown);
endmodule // did_decoder_chk

bind did_decoder did_decoder_chk #(.WORD_W(WORD_W)) did_decoder_chk_inst (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .i_fetch_valid(i_fetch_valid), .i_fetch_word(i_fetch_word),
  .i_cond_true(i_cond_true), .o_fetch_ready(o_fetch_ready),
  .o_op_valid(o_op_valid), .o_op_code(o_op_code), .o_op_word(o_op_word),
  .o_operand(o_operand), .o_op_words(o_op_words),
  .o_op_cycles(o_op_cycles), .o_unknown(o_unknown),
  .o_external_flag_output(o_external_flag_output),
  .o_int_disable(o_int_disable));
`default_nettype wire

//--- tb/did_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module did_fetch_model (
  input  wire logic        i_ref_clk,     // Core clock.
  input  wire logic        i_fetch_ready, // Decoder accepts a word.
  output var  logic        o_fetch_valid, // Word offered.
  output var  logic [15:0] o_fetch_word   // Offered word.
);
  // The fetch path idles with nothing offered.
  initial begin
    o_fetch_valid = 1'b0;
    o_fetch_word = 16'h0000;
  end

  // Offers one word after a gap and holds it until it is taken.
  // A released word line shows the inverse of its last value.
  task automatic send(input logic [15:0] w, input int gap);
    if (gap > 0) begin
      o_fetch_valid = 1'b0;
      o_fetch_word = ~o_fetch_word;
      repeat (gap) @(posedge i_ref_clk);
      #2;
    end
    o_fetch_valid = 1'b1;
    o_fetch_word = w;
    // Ready is registered, so its level at the falling edge is the one
    // that the next rising edge samples; this avoids a race at the edge.
    @(negedge i_ref_clk);
    while (i_fetch_ready !== 1'b1) @(negedge i_ref_clk);
    @(posedge i_ref_clk);
    #2;
  endtask
endmodule // did_fetch_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "did_defs.vh"
module tb_top;
  logic        i_ref_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_cond_true = 1'b0;
  logic        fv, rdy, vld, unk, xf, cy, ovm, tc, sxm, intd, blk;
  logic [15:0] fw, wd, opnd;
  logic [5:0]  code;
  logic [1:0]  nw;
  logic [2:0]  cyc;
  wire  [6:0]  flags = {xf, cy, ovm, tc, sxm, intd, blk};
  int          n_fail = 0;
  int          compares = 0;
  int          ticks = 0;

  did_decoder did_decoder_inst (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_fetch_valid(fv), .i_fetch_word(fw), .i_cond_true(i_cond_true),
    .o_fetch_ready(rdy), .o_op_valid(vld), .o_op_code(code), .o_op_word(wd),
    .o_operand(opnd), .o_op_words(nw), .o_op_cycles(cyc), .o_unknown(unk),
    .o_external_flag_output(xf), .o_carry(cy), .o_ovf_mode(ovm),
    .o_test_flag(tc), .o_sign_ext(sxm), .o_int_disable(intd),
    .o_blk_program(blk));
  did_fetch_model did_fetch_model_inst (.i_ref_clk(i_ref_clk),
    .i_fetch_ready(rdy), .o_fetch_valid(fv), .o_fetch_word(fw));

  // A 40 MHz clock and a cycle ceiling against hangs.
  always #12.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    ticks++;
    if (ticks == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Issues one op (a nonzero operand makes it two words) and checks it.
  task automatic issue(input logic [15:0] w, input logic [15:0] op,
                       input logic [5:0] c, input logic [2:0] n);
    did_fetch_model_inst.send(w, 0);
    if (op !== 16'h0000) did_fetch_model_inst.send(op, 0);
    chk("valid", {15'h0, vld}, 16'h1);
    chk("code", {10'h0, code}, {10'h0, c});
    chk("word", wd, w);
    chk("operand", opnd, op);
    chk("words", {14'h0, nw}, (op !== 16'h0000) ? 16'h2 : 16'h1);
    chk("cycles", {13'h0, cyc}, {13'h0, n});
  endtask

  // A long op must hold off the following fetch for its cycle count.
  task automatic t_stall(input logic [15:0] w, input logic [5:0] c,
                         input logic [2:0] n);
    realtime t0;
    issue(w, 16'h0000, c, n);
    t0 = $realtime;
    issue(16'h7105, 16'h0000, `DID_OP_LTP, 3'h1);
    chk("stall", {15'h0, ($realtime - t0) >= n * 25.0}, 16'h1);
  endtask

  // Words outside the range raise the unknown pulse and issue nothing.
  task automatic t_unknown(input logic [15:0] w);
    did_fetch_model_inst.send(w, 0);
    chk("unknown", {15'h0, unk}, 16'h1);
    chk("no_issue", {15'h0, vld}, 16'h0);
  endtask

  // Each status action sets its own flag and leaves the others alone.
  task automatic t_status();
    logic [3:0] nib [7] = '{4'hd, 4'hf, 4'h3, 4'hb, 4'h7, 4'h1, 4'h5};
    logic [6:0] e = 7'h00;
    chk("flags", {9'h0, flags}, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      issue({12'hbe4, nib[i]}, 16'h0000, `DID_OP_SET_CONTROL_BIT_OP, 3'h1);
      e[6-i] = 1'b1;
      repeat (2) @(posedge i_ref_clk);
      #2;
      chk("flags", {9'h0, flags}, {9'h0, e});
    end
  endtask

  // Reset, then back-to-back decode of every group.
  initial begin
    repeat (10) @(posedge i_ref_clk);
    #2;
    chk("ready_in_reset", {15'h0, rdy}, 16'h0000);
    i_resetn = 1'b1;
    issue(16'h7234, 16'h0, `DID_OP_LOAD_ACC_MOVE, 3'h1);
    issue(16'h7480, 16'h0, `DID_OP_LTS, 3'h1);
    issue(16'ha211, 16'h1234, `DID_OP_MAC, 3'h3);
    issue(16'ha311, 16'hfedc, `DID_OP_MULTIPLY_ACCUMULATE_MOVE_OP, 3'h3);
    issue(16'h8b12, 16'h0, `DID_OP_MAR, 3'h1);
    issue(16'h8b00, 16'h0, `DID_OP_NOP, 3'h1);
    issue(16'h5433, 16'h0, `DID_OP_MPY, 3'h1);
    issue(16'hd123, 16'h0, `DID_OP_MPY_IMM, 3'h1);
    issue(16'h5011, 16'h0, `DID_OP_MULTIPLY_ADD_PREV_OP, 3'h1);
    issue(16'h5122, 16'h0, `DID_OP_MULTIPLY_SUB_PREV_OP, 3'h1);
    issue(16'ha045, 16'h0, `DID_OP_NORMALISE_ACC_OP, 3'h1);
    issue(16'hbfc3, 16'h8001, `DID_OP_OR_SHF, 3'h2);
    issue(16'hbe82, 16'h00ff, `DID_OP_OR_16, 3'h2);
    issue(16'hbe32, 16'h0, `DID_OP_POP_ACC, 3'h1);
    issue(16'h8a10, 16'h0, `DID_OP_POP_TO_MEMORY_OP, 3'h1);
    issue(16'h7611, 16'h0, `DID_OP_PUSH_FROM_MEMORY_OP, 3'h1);
    issue(16'hbe3c, 16'h0, `DID_OP_PUSH_ACC, 3'h1);
    issue(16'hbb7f, 16'h0, `DID_OP_RPT_IMM, 3'h1);
    issue(16'h0b22, 16'h0, `DID_OP_RPT_MEM, 3'h1);
    issue(16'h9c11, 16'h0, `DID_OP_STORE_HIGH_ACC_OP, 3'h1);
    issue(16'h9311, 16'h0, `DID_OP_STORE_LOW_ACC_OP, 3'h1);
    issue(16'hae11, 16'h5a5a, `DID_OP_STORE_LONG_IMMEDIATE_OP, 3'h2);
    issue(16'h6611, 16'h0, `DID_OP_SUBTRACT_NO_SIGNEXT_OP, 3'h1);
    issue(16'h6411, 16'h0, `DID_OP_SUBTRACT_BORROW_OP, 3'h1);
    issue(16'hbfd4, 16'h0f0f, `DID_OP_XOR_SHF, 3'h2);
    issue(16'hbe83, 16'hc3c3, `DID_OP_XOR_16, 3'h2);
    issue(16'h6811, 16'h0, `DID_OP_ZERO_LOAD_ROUND_OP, 3'h1);
    i_cond_true = 1'b0;
    issue(16'hec31, 16'h0, `DID_OP_CONDITIONAL_RETURN_OP, 3'h2);
    i_cond_true = 1'b1;
    t_stall(16'hec31, `DID_OP_CONDITIONAL_RETURN_OP, 3'h4);
    t_stall(16'hef00, `DID_OP_RET, 3'h4);
    t_stall(16'ha611, `DID_OP_TABLE_READ_OP, 3'h3);
    t_stall(16'ha711, `DID_OP_TABLE_WRITE_OP, 3'h3);
    t_unknown(16'hbe40);
    t_unknown(16'h7300);
    t_status();
    wrap_up();
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
endmodule // tb_top
`default_nettype wire
